// *** shared/trig_scan_pkg.sv ***
/*
 * Package for the trigger, scanner and calibration-protect controller:
 * register map, field layouts, reset values, timing counts, types.
 * Assumes a 200 MHz system clock and an AHB-Lite register bus.
 */
package trig_scan_pkg;

	// ------------------------------------------------------------------
	// timing
	// ------------------------------------------------------------------
	localparam int unsigned CLK_MHZ        = 200;
	localparam int unsigned TRIG_LAT_MS    = 10;
	localparam int unsigned BBM_GAP_US     = 2000;
	localparam int unsigned BBM_GAP_CYC    = BBM_GAP_US * CLK_MHZ;
	localparam int unsigned TRIG_MIN_US    = 400;
	localparam int unsigned TRIG_MIN_CYC   = TRIG_MIN_US * CLK_MHZ;

	// ------------------------------------------------------------------
	// scanner
	// ------------------------------------------------------------------
	localparam int unsigned NUM_CH         = 20;
	localparam logic [4:0]  CH_FRONT       = 5'h14;
	localparam logic [4:0]  CH_NONE        = 5'h1F;

	// ------------------------------------------------------------------
	// register offsets (byte addresses)
	// ------------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL        = 8'h00;
	localparam logic [7:0] OFS_CHSEL       = 8'h04;
	localparam logic [7:0] OFS_STATUS      = 8'h08;
	localparam logic [7:0] OFS_STORE_ADDR  = 8'h0C;
	localparam logic [7:0] OFS_STORE_DATA  = 8'h10;
	localparam logic [7:0] OFS_RELAYS      = 8'h14;

	// ctrl fields
	localparam int unsigned CTRL_SINGLE    = 0;
	localparam int unsigned CTRL_TRIG_EN   = 1;
	localparam int unsigned CTRL_FRONT     = 2;
	localparam logic [2:0]  CTRL_RESET     = 3'h0;

	// status fields
	localparam int unsigned ST_BUSY        = 0;
	localparam int unsigned ST_CAL         = 1;
	localparam int unsigned ST_SWITCHING   = 2;
	localparam int unsigned ST_REFUSED     = 3;

	typedef enum logic [1:0] {
		SC_IDLE  = 2'b00,
		SC_BREAK = 2'b01,
		SC_GAP   = 2'b10,
		SC_MAKE  = 2'b11
	} scan_state_t;

	typedef struct packed {
		logic        we;
		logic [7:0]  addr;
		logic [31:0] data;
	} store_wr_t;

endpackage : trig_scan_pkg

// *** hw/trig_scan_ctrl.sv ***
/*
 * Trigger, scanner sequencer and calibration write guard with an
 * AHB-Lite register slave. Assumes one 200 MHz clock; trigger and
 * calibration switch arrive asynchronously from isolated pins.
 */
//
// Functional notes
// - external trigger acts only in single mode
// - start within 10 ms of rising edge
// - new trigger aborts and restarts measurement
// - twenty channels, never more than one closed
// - open old, wait gap, close new
// - channels 00-09 group A, 10-19 group B
// - front output relays switch independently
// - measure setting refuses stored data writes
// - calibration setting lifts protection, calibration mode
// - after reset channels open, trigger disabled
// - front sockets selectable as channel twenty
`timescale 1ns/1ps
module trig_scan_ctrl #(
	// cycles per microsecond; a bench may lower it to shorten the relay gap
	parameter int unsigned US_CYC = trig_scan_pkg::CLK_MHZ
) (
	// clock, reset, enable
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	input  wire logic                     clkEn,
	// ahb-lite slave
	input  wire logic                     hsel,
	input  wire logic [7:0]               haddr,
	input  wire logic [1:0]               htrans,
	input  wire logic                     hwrite,
	input  wire logic [2:0]               hsize,
	input  wire logic [31:0]              hwdata,
	input  wire logic                     hready,
	output logic      [31:0]              hrdata,
	output logic                          hreadyout,
	output logic                          hresp,
	// pins
	input  wire logic                     trigPin,
	input  wire logic                     calSwitchPin,
	// measurement sequencer
	input  wire logic                     measDone,
	output logic                          measStart,
	output logic                          measAbort,
	// scanner relays
	output logic      [9:0]               chanGroupLo,
	output logic      [9:0]               chanGroupHi,
	output logic      [3:0]               frontRelays,
	// store write port
	output trig_scan_pkg::store_wr_t      storeWr,
	output logic                          calMode
);

	// ------------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------------
	logic [2:0] trigSync_r;
	logic [2:0] calSync_r;
	logic       trigLevel_r;
	logic       trigPrev_r;
	logic       calLevel_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			trigSync_r <= 3'h0;
			calSync_r  <= 3'h0;
		end else if (clkEn) begin
			trigSync_r <= {trigSync_r[1:0], trigPin};
			calSync_r  <= {calSync_r[1:0], calSwitchPin};
		end
	end

	// a level changes only once stages two and three agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			trigLevel_r <= 1'b0;
			trigPrev_r  <= 1'b0;
			calLevel_r  <= 1'b0;
		end else if (clkEn) begin
			if (trigSync_r[1] == trigSync_r[2])
				trigLevel_r <= trigSync_r[2];
			trigPrev_r <= trigLevel_r;
			if (calSync_r[1] == calSync_r[2])
				calLevel_r <= calSync_r[2];
		end
	end

	logic trigRise;
	assign trigRise = trigLevel_r & ~trigPrev_r;

	// ------------------------------------------------------------------
	// register state
	// ------------------------------------------------------------------
	logic [2:0]  ctrl_r;
	logic [4:0]  chanReq_r;
	logic [3:0]  relays_r;
	logic [7:0]  storeAddr_r;
	logic        refused_r;
	logic        busy_r;

	logic        dpWrite_r;
	logic        dpRead_r;
	logic [7:0]  dpAddr_r;

	logic        addrPhase;
	assign addrPhase = hsel & hready & htrans[1];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dpWrite_r <= 1'b0;
			dpRead_r  <= 1'b0;
			dpAddr_r  <= 8'h00;
		end else if (clkEn && hready) begin
			dpWrite_r <= addrPhase & hwrite;
			dpRead_r  <= addrPhase & ~hwrite;
			dpAddr_r  <= haddr;
		end
	end

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a[7:2] == ofs[7:2]);
	endfunction : hit

	logic wrCtrl;
	logic wrChan;
	logic wrStore;
	assign wrCtrl  = dpWrite_r & hit(dpAddr_r, trig_scan_pkg::OFS_CTRL);
	assign wrChan  = dpWrite_r & hit(dpAddr_r, trig_scan_pkg::OFS_CHSEL);
	assign wrStore = dpWrite_r & hit(dpAddr_r, trig_scan_pkg::OFS_STORE_DATA);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r      <= trig_scan_pkg::CTRL_RESET;
			chanReq_r   <= trig_scan_pkg::CH_NONE;
			relays_r    <= 4'h0;
			storeAddr_r <= 8'h00;
		end else if (clkEn) begin
			if (wrCtrl)
				ctrl_r <= hwdata[2:0];
			// out-of-range numbers deselect rather than alias
			if (wrChan)
				chanReq_r <= (hwdata[4:0] > trig_scan_pkg::CH_FRONT) ?
					trig_scan_pkg::CH_NONE : hwdata[4:0];
			if (dpWrite_r && hit(dpAddr_r, trig_scan_pkg::OFS_RELAYS))
				relays_r <= hwdata[3:0];
			if (dpWrite_r && hit(dpAddr_r, trig_scan_pkg::OFS_STORE_ADDR))
				storeAddr_r <= hwdata[7:0];
		end
	end

	// ------------------------------------------------------------------
	// calibration write guard
	// ------------------------------------------------------------------
	assign calMode = calLevel_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			storeWr   <= '0;
			refused_r <= 1'b0;
		end else if (clkEn) begin
			storeWr.we   <= wrStore & calLevel_r;
			storeWr.addr <= storeAddr_r;
			if (wrStore)
				storeWr.data <= hwdata;
			// sticky until status is read; a new refusal wins over the clear
			if (wrStore && !calLevel_r)
				refused_r <= 1'b1;
			else if (dpRead_r && hit(dpAddr_r, trig_scan_pkg::OFS_STATUS))
				refused_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// trigger to measurement start
	// ------------------------------------------------------------------
	logic trigAccept;
	assign trigAccept = trigRise & ctrl_r[trig_scan_pkg::CTRL_SINGLE]
		& ctrl_r[trig_scan_pkg::CTRL_TRIG_EN];

	// start issued five cycles after pin edge, far inside the latency bound
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			measStart <= 1'b0;
			measAbort <= 1'b0;
			busy_r    <= 1'b0;
		end else if (clkEn) begin
			measStart <= trigAccept;
			measAbort <= trigAccept & busy_r;
			if (trigAccept)
				busy_r <= 1'b1;
			else if (measDone)
				busy_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// break-before-make scanner sequencer
	// ------------------------------------------------------------------
	trig_scan_pkg::scan_state_t scanState_r;
	logic [4:0]  chanOn_r;
	logic [4:0]  chanTgt_r;
	logic [19:0] gapCnt_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scanState_r <= trig_scan_pkg::SC_IDLE;
			chanOn_r    <= trig_scan_pkg::CH_NONE;
			chanTgt_r   <= trig_scan_pkg::CH_NONE;
			gapCnt_r    <= 20'h00000;
		end else if (clkEn) begin
			case (scanState_r)
				trig_scan_pkg::SC_IDLE: begin
					if (chanReq_r != chanOn_r) begin
						chanTgt_r   <= chanReq_r;
						scanState_r <= trig_scan_pkg::SC_BREAK;
					end
				end
				trig_scan_pkg::SC_BREAK: begin
					chanOn_r    <= trig_scan_pkg::CH_NONE;
					gapCnt_r    <= 20'(trig_scan_pkg::BBM_GAP_US * US_CYC - 1);
					scanState_r <= (chanTgt_r == trig_scan_pkg::CH_NONE) ?
						trig_scan_pkg::SC_IDLE : trig_scan_pkg::SC_GAP;
				end
				trig_scan_pkg::SC_GAP: begin
					if (gapCnt_r == 20'h00000)
						scanState_r <= trig_scan_pkg::SC_MAKE;
					else
						gapCnt_r <= gapCnt_r - 20'h00001;
				end
				trig_scan_pkg::SC_MAKE: begin
					chanOn_r    <= chanTgt_r;
					scanState_r <= trig_scan_pkg::SC_IDLE;
				end
				default: scanState_r <= trig_scan_pkg::SC_IDLE;
			endcase
		end
	end

	// one-hot decode guarantees at most one relay closed
	logic [19:0] chanOneHot;
	genvar gi;
	generate
		for (gi = 0; gi < 20; gi++) begin : g_dec
			assign chanOneHot[gi] = (chanOn_r == 5'(gi));
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			chanGroupLo <= 10'h000;
			chanGroupHi <= 10'h000;
			frontRelays <= 4'h0;
		end else if (clkEn) begin
			chanGroupLo <= chanOneHot[9:0];
			chanGroupHi <= chanOneHot[19:10];
			frontRelays <= (ctrl_r[trig_scan_pkg::CTRL_FRONT] ||
				chanOn_r == trig_scan_pkg::CH_FRONT) ? relays_r : 4'h0;
		end
	end

	// ------------------------------------------------------------------
	// read data
	// ------------------------------------------------------------------
	logic [31:0] rdMux;
	always_comb begin
		rdMux = 32'h00000000;
		if (hit(haddr, trig_scan_pkg::OFS_CTRL))
			rdMux = {29'h0, ctrl_r};
		else if (hit(haddr, trig_scan_pkg::OFS_CHSEL))
			rdMux = {19'h0, chanOn_r, 3'h0, chanReq_r};
		else if (hit(haddr, trig_scan_pkg::OFS_STATUS))
			rdMux = {28'h0, refused_r, (scanState_r != trig_scan_pkg::SC_IDLE),
				calLevel_r, busy_r};
		else if (hit(haddr, trig_scan_pkg::OFS_STORE_ADDR))
			rdMux = {24'h0, storeAddr_r};
		else if (hit(haddr, trig_scan_pkg::OFS_RELAYS))
			rdMux = {28'h0, relays_r};
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			hrdata <= 32'h00000000;
		else if (clkEn && addrPhase && !hwrite)
			hrdata <= rdMux;
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

endmodule : trig_scan_ctrl

// *** tb/trig_scan_ctrl_sva.sv ***
/* Concurrent checks on trig_scan_ctrl ports.
   Assumes one clock and the async active-low reset of the block. */
`timescale 1ns/1ps
module trig_scan_ctrl_sva #(
	// cycles per microsecond, taken from the bound design
	parameter int unsigned US_CYC = trig_scan_pkg::CLK_MHZ
) (
	// clock and reset
	input wire logic                     clk,
	input wire logic                     rst_n,
	// watched ports
	input wire logic                     trigPin,
	input wire logic                     measStart,
	input wire logic                     measAbort,
	input wire logic [9:0]               chanGroupLo,
	input wire logic [9:0]               chanGroupHi,
	input wire trig_scan_pkg::store_wr_t storeWr,
	input wire logic                     calMode
);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// counters start saturated so a cold start never looks like a violation
	// 1 ms floor of the open time between break and make
	localparam int GAP_MIN = 1000 * US_CYC;
	int openCnt;
	int riseAge;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			openCnt <= GAP_MIN;
			riseAge <= 99;
		end else begin
			if ({chanGroupHi, chanGroupLo} != 20'h00000) openCnt <= 0;
			else if (openCnt < GAP_MIN) openCnt <= openCnt + 1;
			if ($rose(trigPin)) riseAge <= 0;
			else if (riseAge < 99) riseAge <= riseAge + 1;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence relayMake;
		$rose(|{chanGroupHi, chanGroupLo});
	endsequence
	sequence restart;
		measAbort;
	endsequence
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	chk_one_hot: assert property ($onehot0({chanGroupHi, chanGroupLo}))
		else $error("more than one relay closed");
	chk_break_first: assert property (($past({chanGroupHi, chanGroupLo}) != 20'h00000
		&& {chanGroupHi, chanGroupLo} != 20'h00000) |-> $stable({chanGroupHi, chanGroupLo}))
		else $error("relay moved without opening first");
	chk_gap_min: assert property (relayMake |-> openCnt >= GAP_MIN)
		else $error("make came too soon after break");
	chk_start_trig: assert property (measStart |-> riseAge < 12)
		else $error("start without a recent trigger edge");
	chk_start_once: assert property (measStart |=> !measStart [*4])
		else $error("trigger edge gave more than one start");
	chk_abort_restart: assert property (restart |-> measStart)
		else $error("abort without restart");
	chk_store_guard: assert property (storeWr.we |-> $past(calMode))
		else $error("store written in measure setting");
	chk_reset_open: assert property ($rose(rst_n) |-> !measStart
		&& {chanGroupHi, chanGroupLo} == 20'h00000)
		else $error("not idle after reset");
endmodule : trig_scan_ctrl_sva

bind trig_scan_ctrl trig_scan_ctrl_sva #(.US_CYC(US_CYC)) trig_scan_ctrl_sva_i (.clk(clk),
	.rst_n(rst_n), .trigPin(trigPin), .measStart(measStart), .measAbort(measAbort),
	.chanGroupLo(chanGroupLo), .chanGroupHi(chanGroupHi), .storeWr(storeWr),
	.calMode(calMode));

// *** tb/trig_relay_model.sv ***
/* Far side: trigger source and scanner relay bank.
   Assumes the bench calls pulse() right after a rising clock edge. */
`timescale 1ns/1ps
module trig_relay_model #(
	// cycles per microsecond, matched to the design under test
	parameter int unsigned US_CYC = trig_scan_pkg::CLK_MHZ
) (
	// clock
	input wire logic       clk,
	// relay drives
	input wire logic [9:0] chanGroupLo,
	input wire logic [9:0] chanGroupHi,
	// trigger source
	output logic           trigPin
);
	// ------------------------------------------------------------
	// trigger source
	// ------------------------------------------------------------
	localparam int HOLD_CYC = trig_scan_pkg::TRIG_MIN_US * US_CYC + 20;
	initial trigPin = 1'b0;
	task automatic pulse();
		trigPin <= 1'b1;
		repeat (HOLD_CYC) @(posedge clk);
		trigPin <= 1'b0;
		repeat (50) @(posedge clk);
	endtask : pulse
	// closed channel number, 31 when every relay is open
	function automatic logic [4:0] closedCh();
		logic [19:0] all;
		all = {chanGroupHi, chanGroupLo};
		closedCh = 5'h1F;
		for (int i = 0; i < 20; i++) if (all[i]) closedCh = 5'(i);
	endfunction : closedCh
endmodule : trig_relay_model

// *** tb/tb_trig_scan_ctrl.sv ***
/* Bench for trig_scan_ctrl: AHB-Lite tasks and directed sequences.
   Assumes a scaled microsecond of US_CYC cycles shared by design, model and checker. */
`timescale 1ns/1ps
module tb_trig_scan_ctrl;
	// short microsecond keeps the 2 ms gap and 400 us pulses cheap to run
	localparam int unsigned US_CYC = 5;
	logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, measDone = 0, calSwitchPin = 0;
	logic [7:0]  haddr = 8'h00;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] hwdata = 32'h00000000, hrdata, q;
	logic        hreadyout, hresp, trigPin, measStart, measAbort, calMode;
	logic [9:0]  chanGroupLo, chanGroupHi;
	logic [3:0]  frontRelays;
	trig_scan_pkg::store_wr_t storeWr, lastWr;
	int n_fail = 0, tests_run = 0, starts = 0, aborts = 0, wrs = 0, cyc = 0, t0;
	always #2.5 clk = ~clk;
	trig_scan_ctrl #(.US_CYC(US_CYC)) trig_scan_ctrl_i (.clk(clk), .rst_n(rst_n),
		.clkEn(1'b1), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.trigPin(trigPin), .calSwitchPin(calSwitchPin), .measDone(measDone),
		.measStart(measStart), .measAbort(measAbort), .chanGroupLo(chanGroupLo),
		.chanGroupHi(chanGroupHi), .frontRelays(frontRelays), .storeWr(storeWr),
		.calMode(calMode));
	trig_relay_model #(.US_CYC(US_CYC)) trig_relay_model_i (.clk(clk), .chanGroupLo(chanGroupLo),
		.chanGroupHi(chanGroupHi), .trigPin(trigPin));
	// ------------------------------------------------------------
	// monitors, timeout, tasks
	// ------------------------------------------------------------
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (measStart === 1'b1) starts <= starts + 1;
		if (measAbort === 1'b1) aborts <= aborts + 1;
		if (storeWr.we === 1'b1) begin
			wrs <= wrs + 1;
			lastWr <= storeWr;
		end
		// the sequence needs about 40k cycles
		if (cyc == 80000) begin
			n_fail = n_fail + 1;
			stop_test();
		end
	end
	task automatic stop_test();
		if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : stop_test
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		q = hrdata;
		chk("hresp", 32'h0, 32'(hresp));
	endtask : bus
	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		bus(0, trig_scan_pkg::OFS_CTRL, 32'h0); chk("ctrl", 32'h0, q);
		chk("relays", 32'h0, 32'({chanGroupHi, chanGroupLo}));
		bus(1, 8'h20, 32'hFFFFFFFF);
		bus(0, 8'h20, 32'h0); chk("unmapped", 32'h0, q);
		bus(1, trig_scan_pkg::OFS_CTRL, 32'h2);
		trig_relay_model_i.pulse(); chk("startOff", 32'h0, starts);
		bus(1, trig_scan_pkg::OFS_CTRL, 32'h3);
		trig_relay_model_i.pulse(); chk("start", 32'h1, starts);
		trig_relay_model_i.pulse(); chk("restart", 32'h2, starts);
		chk("abort", 32'h1, aborts);
		measDone <= 1'b1;
		@(posedge clk);
		measDone <= 1'b0;
		bus(0, trig_scan_pkg::OFS_STATUS, 32'h0); chk("busy", 32'h0, q & 32'h1);
		trig_relay_model_i.pulse(); chk("freshStart", 32'h3, starts);
		chk("noAbort", 32'h1, aborts);
		bus(1, trig_scan_pkg::OFS_STORE_ADDR, 32'h5A);
		bus(1, trig_scan_pkg::OFS_STORE_DATA, 32'hCAFE0001);
		repeat (4) @(posedge clk); chk("refusedWr", 32'h0, wrs);
		bus(0, trig_scan_pkg::OFS_STATUS, 32'h0); chk("refused", 32'h8, q & 32'hA);
		calSwitchPin <= 1'b1;
		repeat (20) @(posedge clk);
		bus(0, trig_scan_pkg::OFS_STATUS, 32'h0); chk("calMode", 32'h2, q & 32'hA);
		chk("calModePin", 32'h1, 32'(calMode));
		bus(1, trig_scan_pkg::OFS_STORE_DATA, 32'hCAFE0002);
		repeat (4) @(posedge clk); chk("wr", 32'h1, wrs);
		chk("wrData", 32'hCAFE0002, lastWr.data);
		chk("wrAddr", 32'h5A, 32'(lastWr.addr));
		calSwitchPin <= 1'b0;
		// each move onto a channel waits the scaled 2 ms relay gap; deselecting opens at once
		bus(1, trig_scan_pkg::OFS_CHSEL, 32'h5);
		while ({chanGroupHi, chanGroupLo} == 20'h00000) @(posedge clk);
		chk("ch5", 32'h20, 32'({chanGroupHi, chanGroupLo}));
		chk("calOff", 32'h0, 32'(calMode));
		bus(1, trig_scan_pkg::OFS_CHSEL, 32'hC);
		while ({chanGroupHi, chanGroupLo} != 20'h00000) @(posedge clk);
		t0 = cyc;
		while ({chanGroupHi, chanGroupLo} == 20'h00000) @(posedge clk);
		chk("ch12", 32'h1000, 32'({chanGroupHi, chanGroupLo}));
		chk("chNum", 32'hC, 32'(trig_relay_model_i.closedCh()));
		chk("gap", 32'h1, 32'(cyc - t0 >= 1000 * US_CYC && cyc - t0 <= 3000 * US_CYC));
		bus(0, trig_scan_pkg::OFS_CHSEL, 32'h0); chk("chsel", 32'hC0C, q);
		bus(1, trig_scan_pkg::OFS_CHSEL, 32'h17);
		repeat (10) @(posedge clk);
		chk("none", 32'h0, 32'({chanGroupHi, chanGroupLo}));
		bus(0, trig_scan_pkg::OFS_CHSEL, 32'h0); chk("chselNone", 32'h1F1F, q);
		bus(1, trig_scan_pkg::OFS_RELAYS, 32'h5);
		bus(1, trig_scan_pkg::OFS_CTRL, 32'h4);
		repeat (4) @(posedge clk); chk("front", 32'h5, 32'(frontRelays));
		bus(1, trig_scan_pkg::OFS_CTRL, 32'h0);
		repeat (4) @(posedge clk); chk("frontOff", 32'h0, 32'(frontRelays));
		bus(1, trig_scan_pkg::OFS_CHSEL, 32'h14);
		while (frontRelays == 4'h0) @(posedge clk);
		chk("front20", 32'h5, 32'(frontRelays));
		chk("front20Scan", 32'h0, 32'({chanGroupHi, chanGroupLo}));
		stop_test();
	end
endmodule : tb_trig_scan_ctrl
